// [clk_cfg_pkg.sv]
// Constants shared by the clock-rate and thermal-limit configuration block.
// Assumes a 100 MHz system clock and an AHB-Lite register bus of 32-bit words.
package clk_cfg_pkg;

    // ************************************************************
    // Register map and reset values
    // ************************************************************
    localparam logic [7:0] cfg_a_offset = 8'h00;
    localparam logic [7:0] cfg_a_reset = 8'h63;
    localparam logic [7:0] status_offset = 8'h04;
    localparam int fault_bypass_bit = 7;
    localparam int adjust_bypass_bit = 6;
    localparam int recovery_bypass_bit = 5;
    localparam int interp_lsb = 3;
    localparam int ratio_lsb = 0;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [1:0] interp_up2 = 2'h0;
    localparam logic [1:0] interp_pass = 2'h1;
    localparam logic [1:0] interp_down2 = 2'h2;
    localparam logic [2:0] ratio_code_na = 3'h5;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int clk_period_ns = 10;
    localparam int warn_hold_ms = 400;
    localparam int warn_hold_cycles = warn_hold_ms * 1000000 / clk_period_ns;

    // Internal clock rates in Hz, per sampling family.
    localparam int iclk_32k_hz = 32768000;
    localparam int iclk_44k_hz = 45158400;
    localparam int iclk_48k_hz = 49152000;

    typedef enum logic [1:0]
    {
        th_normal = 2'b00,
        th_limited = 2'b01,
        th_latched = 2'b11
    } thermal_state_t;

endpackage

// [warn_timer.sv]
// Counts how long the thermal warning has stood and flags when it passes the limit.
// Assumes the warning level is already synchronous to clk_sys.
`timescale 1ns/10ps
module warn_timer #(
    parameter int hold_cycles = clk_cfg_pkg::warn_hold_cycles
)
(
    input wire logic clk_sys, // System clock.
    input wire logic rst_n, // Synchronised reset, active low.
    input wire logic warn_active, // Warning present.
    output logic expired // Warning held longer than the limit.
);
    logic [31:0] count_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= 32'h0;
        else if (!warn_active)
            count_q <= 32'h0;
        else if (count_q <= 32'(hold_cycles))
            count_q <= count_q + 32'h1;
    end

    // Strictly longer than the limit, so expiry needs one count beyond it.
    assign expired = warn_active && (count_q > 32'(hold_cycles));

    a_count_advances: assert property (@(posedge clk_sys) disable iff (!rst_n)
        warn_active && !expired |=> count_q == $past(count_q) + 32'h1)
        else $error("Warning timer did not advance.");
endmodule

// [clk_cfg.sv]
// Configuration register for clock ratio, interpolation and thermal limiting.
// Assumes a single AHB-Lite master driving single word transfers on clk_sys.
//
// Summary of operation
// - Register at 0x00 holds fault, adjust and recovery bypass, interp and ratio, reset 0x63.
// - The ratio field sets the multiplication factor of the internal clock generator.
// - With interp 00, codes 101 to 000 mean 576,128,256,384,512,768 times fs.
// - With interp 01, codes 100 to 000 mean 64,128,192,256,384 times fs; 101 is invalid.
// - With interp 1X, codes 100 to 000 mean 32,64,96,128,192 times fs; 101 is invalid.
// - The internal clock is 32.768, 45.1584 or 49.152 MHz by sampling family.
// - Sampling rates of 32, 44.1, 48, 88.2, 96, 176.4 and 192 kHz are accepted.
// - The interp field sits in bits 4:3, resets to 00 and picks first-stage oversampling.
// - Interp 00 upsamples by two, 01 passes through, 10 downsamples by two.
// - Recovery bypass is bit 5, resets to 1; 0 enables and 1 disables recovery.
// - Recovery bypass only decides limit removal and only while adjust bypass is 0.
// - With both bypasses 0, a cleared warning removes the limit and restores gain.
// - With recovery bypass 1, the limit stays until recovery bypass is 0, adjust bypass is 1 or reset.
// - With adjust bypass 0, a warning held over 400 ms imposes the -3 dB limit.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
module clk_cfg #(
    parameter int warn_hold_cycles = clk_cfg_pkg::warn_hold_cycles
)
(
    input wire logic clk_sys, // System clock, 100 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic hsel, // AHB slave select.
    input wire logic [31:0] haddr, // AHB address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write.
    input wire logic [2:0] hsize, // AHB size.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic [31:0] hrdata, // AHB read data.
    output logic hreadyout, // AHB slave ready.
    output logic hresp, // AHB response, always OKAY.
    input wire logic thermal_warning_in_n, // Thermal warning, active low.
    input wire logic sample_cfg_strobe, // Start of a new sampling configuration.
    output logic [2:0] pll_ratio_sel, // Applied ratio code.
    output logic [1:0] interp_ratio_sel, // Applied interpolation code.
    output logic [9:0] mclk_ratio, // Master clock over fs, zero when invalid.
    output logic ratio_invalid, // Applied ratio code not available.
    output logic fault_recovery_bypass, // Bypass of fault recovery.
    output logic thermal_limit_active // The -3 dB output limit is in force.
);
    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic wr_pend_q;
    logic [7:0] addr_q;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic rd_hit;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h0;
        end
        else if (hready)
        begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            addr_q <= haddr[7:0];
        end
    end

    // The slave never waits; only haddr[7:0] is decoded, and other offsets in it read zero and ignore writes.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb
    begin
        cfg_d = cfg_q;
        if (wr_pend_q && addr_q == clk_cfg_pkg::cfg_a_offset)
            cfg_d = hwdata[7:0];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cfg_q <= clk_cfg_pkg::cfg_a_reset;
        else
            cfg_q <= cfg_d;
    end

    logic adjust_bypass;
    logic recovery_bypass;
    logic [2:0] ratio_field;
    logic [1:0] interp_field;

    assign adjust_bypass = cfg_q[clk_cfg_pkg::adjust_bypass_bit];
    assign recovery_bypass = cfg_q[clk_cfg_pkg::recovery_bypass_bit];
    assign ratio_field = cfg_q[clk_cfg_pkg::ratio_lsb +: 3];
    assign interp_field = cfg_q[clk_cfg_pkg::interp_lsb +: 2];
    assign fault_recovery_bypass = cfg_q[clk_cfg_pkg::fault_bypass_bit];

    // ************************************************************
    // Clock ratio selection
    // ************************************************************
    // ratios for every interp mode, scaled down from the upsampling table
    function automatic logic [9:0] ratio_of(input logic [1:0] isel, input logic [2:0] code);
        logic [9:0] base;
        base = 10'h0;
        case (code)
            3'h5: base = (isel == clk_cfg_pkg::interp_up2) ? 10'h240 : 10'h0;
            3'h4: base = 10'h080;
            3'h3: base = 10'h100;
            3'h2: base = 10'h180;
            3'h1: base = 10'h200;
            3'h0: base = 10'h300;
            default: base = 10'h0;
        endcase
        // Each halving of the first-stage rate halves the master clock ratio.
        if (code == 3'h5)
            return base;
        else if (isel == clk_cfg_pkg::interp_up2)
            return base;
        else if (isel == clk_cfg_pkg::interp_pass)
            return {1'b0, base[9:1]};
        else
            return {2'b00, base[9:2]};
    endfunction

    logic [2:0] ratio_q;
    logic [1:0] interp_q;

    // applied ratio code and first-stage mode
    // Fields apply only at a sampling setup, so a half-written setting never glitches the loop.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ratio_q <= clk_cfg_pkg::cfg_a_reset[2:0];
            interp_q <= clk_cfg_pkg::cfg_a_reset[4:3];
        end
        else if (sample_cfg_strobe)
        begin
            ratio_q <= ratio_field;
            interp_q <= interp_field;
        end
    end

    logic [9:0] mclk_ratio_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            mclk_ratio_q <= 10'h0;
        else
            mclk_ratio_q <= ratio_of(interp_q, ratio_q);
    end

    assign pll_ratio_sel = ratio_q;
    assign interp_ratio_sel = interp_q;
    assign mclk_ratio = mclk_ratio_q;
    assign ratio_invalid = (mclk_ratio_q == 10'h0);

    // ************************************************************
    // Thermal output limit
    // ************************************************************
    logic warn_active;
    logic warn_expired;

    assign warn_active = !thermal_warning_in_n;

    warn_timer #(
        .hold_cycles(warn_hold_cycles)
    ) u_warn_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .warn_active(warn_active),
        .expired(warn_expired)
    );

    clk_cfg_pkg::thermal_state_t th_q;
    clk_cfg_pkg::thermal_state_t th_d;

    always_comb
    begin
        th_d = th_q;
        case (th_q)
            clk_cfg_pkg::th_normal:
                if (!adjust_bypass && warn_expired)
                    th_d = clk_cfg_pkg::th_limited;
            clk_cfg_pkg::th_limited:
                if (adjust_bypass)
                    th_d = clk_cfg_pkg::th_normal;
                else if (!warn_active)
                    th_d = recovery_bypass ? clk_cfg_pkg::th_latched : clk_cfg_pkg::th_normal;
            clk_cfg_pkg::th_latched:
                if (adjust_bypass || !recovery_bypass)
                    th_d = clk_cfg_pkg::th_normal;
                else if (warn_active)
                    th_d = clk_cfg_pkg::th_limited;
            default:
                th_d = clk_cfg_pkg::th_normal;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            th_q <= clk_cfg_pkg::th_normal;
        else
            th_q <= th_d;
    end

    assign thermal_limit_active = (th_q != clk_cfg_pkg::th_normal);

    // ************************************************************
    // Read data
    // ************************************************************
    logic [31:0] rdata_q;

    assign rd_hit = hready && hsel && htrans[1] && !hwrite;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 32'h0;
        else if (rd_hit && haddr[7:0] == clk_cfg_pkg::cfg_a_offset)
            rdata_q <= {24'h0, cfg_d};
        else if (rd_hit && haddr[7:0] == clk_cfg_pkg::status_offset)
            rdata_q <= {19'h0, thermal_limit_active, warn_active, ratio_invalid, mclk_ratio_q};
        else if (rd_hit)
            rdata_q <= 32'h0;
    end

    assign hrdata = rdata_q;

    // ************************************************************
    // Checks
    // ************************************************************
    a_cfg_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_pend_q && addr_q == 8'h00 |=> cfg_q == $past(hwdata[7:0]))
        else $error("Register write not stored.");

    a_reset_value: assert property (@(posedge clk_sys)
        $rose(rst_n) |-> cfg_q == 8'h63)
        else $error("Register reset value wrong.");

    a_limit_on_expiry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        th_q == clk_cfg_pkg::th_normal && !adjust_bypass && warn_expired
        |=> thermal_limit_active)
        else $error("Limit not imposed after long warning.");

    a_no_limit_bypassed: assert property (@(posedge clk_sys) disable iff (!rst_n)
        adjust_bypass && th_q == clk_cfg_pkg::th_normal |=> !thermal_limit_active)
        else $error("Limit imposed while adjustment bypassed.");

    a_recover_on_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        th_q == clk_cfg_pkg::th_limited && !warn_active && !adjust_bypass && !recovery_bypass
        |=> !thermal_limit_active)
        else $error("Limit not removed after warning cleared.");

    a_latched_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        th_q == clk_cfg_pkg::th_limited && !warn_active && !adjust_bypass && recovery_bypass
        |=> thermal_limit_active ##1
            (thermal_limit_active || $past(adjust_bypass) || !$past(recovery_bypass)))
        else $error("Limit released while recovery bypassed.");

    a_ratio_up_table: assert property (@(posedge clk_sys) disable iff (!rst_n)
        interp_q == 2'h0 && ratio_q == 3'h5 && $stable(ratio_q) && $stable(interp_q)
        |=> mclk_ratio == 10'd576)
        else $error("Ratio 576 not produced.");

    a_ratio_down_table: assert property (@(posedge clk_sys) disable iff (!rst_n)
        interp_q[1] && ratio_q == 3'h0 && $stable(ratio_q) && $stable(interp_q)
        |=> mclk_ratio == 10'd192)
        else $error("Ratio 192 not produced.");

    a_ratio_na_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
        interp_q == 2'h1 && ratio_q == 3'h5 && $stable(ratio_q) && $stable(interp_q)
        |=> ratio_invalid)
        else $error("Unavailable code not flagged.");
endmodule

// [host_bus_model.sv]
// AHB-Lite master that stands in for the host programming the configuration block.
// Assumes one slave whose hreadyout is the bus hready; tasks are entered just after an edge.
`timescale 1ns/10ps
module host_bus_model
(
    input wire logic clk_sys, // System clock.
    input wire logic hready, // Bus ready.
    input wire logic [31:0] hrdata, // Read data.
    output logic hsel, // Slave select.
    output logic [31:0] haddr, // Byte address.
    output logic [1:0] htrans, // Transfer type.
    output logic hwrite, // Write direction.
    output logic [2:0] hsize, // Always a word.
    output logic [31:0] hwdata // Write data.
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One single transfer; the wait on hready has no limit of its own.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        q = hrdata;
        // Released data lines show no stale value.
        hwdata <= ~d;
    endtask

    function automatic logic [1:0] interp_for(input int fs_hz);
        return (fs_hz > 100000) ? 2'h2 : ((fs_hz > 50000) ? 2'h1 : 2'h0);
    endfunction
endmodule

// [tb_top.sv]
// Self-checking bench for the clock-rate and thermal-limit configuration block.
// Assumes the block answers AHB-Lite transfers; the host model waits on hready each phase.
`timescale 1ns/10ps
module tb_top;
    localparam int hold = 20;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic warn_n = 1'b1;
    logic strobe = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, ratio_invalid, fault_bypass, limit;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, interp;
    logic [2:0] hsize, pll;
    logic [9:0] mclk;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int rates[7] = '{32000, 44100, 48000, 88200, 96000, 176400, 192000};

    always #5 clk_sys = ~clk_sys;

    clk_cfg #(.warn_hold_cycles(hold)) DUT (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .thermal_warning_in_n(warn_n), .sample_cfg_strobe(strobe), .pll_ratio_sel(pll),
        .interp_ratio_sel(interp), .mclk_ratio(mclk), .ratio_invalid(ratio_invalid),
        .fault_recovery_bypass(fault_bypass), .thermal_limit_active(limit));

    host_bus_model host (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
        host.xfer(1'b0, a, 32'h0, rd);
        check(rd, exp, msg);
    endtask

    task automatic apply(input logic [7:0] cfg);
        wr(32'h0, {24'h0, cfg});
        strobe <= 1'b1;
        @(posedge clk_sys);
        strobe <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic warn_for(input int n);
        warn_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic [9:0] exp_ratio(input logic [1:0] isel, input logic [2:0] c);
        int t0[6] = '{768, 512, 384, 256, 128, 576};
        int t1[6] = '{384, 256, 192, 128, 64, 0};
        int t2[6] = '{192, 128, 96, 64, 32, 0};
        if (isel == 2'h0)
            return 10'(t0[c]);
        if (isel == 2'h1)
            return 10'(t1[c]);
        return 10'(t2[c]);
    endfunction

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_register();
        rd_chk(32'h0, 32'h63, "reset value");
        check({pll, interp, fault_bypass, limit, hresp}, {3'h3, 2'h0, 3'h0}, "reset outs");
        wr(32'h0, 32'hff);
        rd_chk(32'h0, 32'hff, "all ones");
        check(fault_bypass, 1'b1, "fault bypass bit");
        check(pll, 3'h3, "ratio before strobe");
        wr(32'h0, 32'h0);
        wr(32'h8, 32'h5a);
        rd_chk(32'h0, 32'h0, "all zeros");
        rd_chk(32'h8, 32'h0, "unmapped read");
    endtask

    task automatic t_table();
        for (int sel = 0; sel < 4; sel++)
            for (int c = 0; c < 6; c++)
            begin
                apply({3'h3, sel[1:0], c[2:0]});
                check(mclk, exp_ratio(sel[1:0], c[2:0]), "ratio");
                check(ratio_invalid, (c == 5 && sel != 0), "invalid");
                check({interp, pll}, {sel[1:0], c[2:0]}, "applied codes");
            end
    endtask

    task automatic t_rates();
        logic [1:0] sel;
        int fam;
        foreach (rates[i])
        begin
            sel = host.interp_for(rates[i]);
            fam = (rates[i] % 44100 == 0) ? clk_cfg_pkg::iclk_44k_hz :
                ((rates[i] == 32000) ? clk_cfg_pkg::iclk_32k_hz : clk_cfg_pkg::iclk_48k_hz);
            apply({3'h3, sel, 3'h3});
            check(mclk, exp_ratio(sel, 3'h3), "rate family");
            check(ratio_invalid, 1'b0, "whole ratio");
            check(rates[i] * (1024 >> interp), fam, "internal clock");
        end
    endtask

    task automatic t_thermal();
        apply(8'h00);
        warn_for(hold - 3);
        check(limit, 1'b0, "limit too early");
        repeat (10) @(posedge clk_sys);
        check(limit, 1'b1, "limit imposed");
        rd_chk(32'h4, 32'h1b00, "status word");
        warn_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(limit, 1'b0, "recovered");
        wr(32'h0, 32'h20);
        warn_for(hold + 7);
        warn_n <= 1'b1;
        repeat (hold) @(posedge clk_sys);
        check(limit, 1'b1, "limit latched");
        wr(32'h0, 32'h0);
        repeat (2) @(posedge clk_sys);
        check(limit, 1'b0, "latch released");
        wr(32'h0, 32'h20);
        warn_for(hold + 7);
        warn_n <= 1'b1;
        do_reset();
        check(limit, 1'b0, "reset clears limit");
        rd_chk(32'h0, 32'h63, "reset again");
        for (int k = 0; k < 2; k++)
        begin
            wr(32'h0, k ? 32'h60 : 32'h40);
            warn_for(hold + 7);
            check(limit, 1'b0, "adjust bypassed");
            warn_n <= 1'b1;
            @(posedge clk_sys);
        end
    endtask

    initial
    begin
        do_reset();
        t_register();
        t_table();
        t_rates();
        t_thermal();
        stop_test();
    end
endmodule
